// ### rtl/display_mode_command_decoder.v
// display mode command decoder: link receiver, mode flags, pixel path
`timescale 1ns/100ps
`default_nettype none
`include "display_cmd_map.vh"
module display_mode_command_decoder (
  input wire sys_clk_in,
  input wire srst_in,
  input wire link_clk_in,
  input wire link_sel_n_in,
  input wire link_dc_in,
  input wire link_data_in,
  input wire sleep_in,
  input wire normal_mode_cmd_in,
  input wire partial_mode_cmd_in,
  input wire [23:0] pixel_in,
  input wire pixel_valid_in,
  input wire mem_start_in,
  input wire mem_step_in,
  output reg [23:0] pixel_out,
  output reg pixel_valid_out,
  output reg frame_sync_out,
  output reg [1:0] gamma_curve_out,
  output wire row_order_out,
  output wire col_order_out,
  output wire row_col_swap_out,
  output wire vert_refresh_out,
  output wire filter_order_out,
  output wire horiz_refresh_out,
  output wire source_scan_flip_out,
  output wire gate_scan_flip_out,
  output reg [10:0] mem_col_out,
  output reg [11:0] mem_page_out,
  output reg [6:0] mode_status_out
);
  // synchronised link levels
  wire link_clk_lvl;
  wire link_sel_n_lvl;
  wire link_dc_lvl;
  wire link_data_lvl;
  reg link_clk_prev;
  wire link_rise;
  // byte assembly
  reg [6:0] shift;
  reg [2:0] bit_cnt;
  reg byte_done;
  reg byte_is_param;
  reg [7:0] byte_val;
  // command state
  reg param_pending;
  reg [7:0] pending_op;
  // mode flags and parameter registers
  reg invert_on;
  reg force_black;
  reg force_white;
  reg blank_on;
  reg sync_on;
  reg reduced_color;
  reg [7:0] scan_order_control;
  reg [7:0] sync_output_mode;
  // timing
  reg [1:0] dot_div;
  reg dot_en;
  wire hblank;
  wire vblank;
  reg [23:0] next_pixel;

  pin_sync #(.RESET_LEVEL(1'b0)) sync_clk (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(link_clk_in),
    .level_out(link_clk_lvl)
  );
  pin_sync #(.RESET_LEVEL(1'b1)) sync_sel (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(link_sel_n_in),
    .level_out(link_sel_n_lvl)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) sync_dc (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(link_dc_in),
    .level_out(link_dc_lvl)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) sync_data (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(link_data_in),
    .level_out(link_data_lvl)
  );

  // clock and data pass matching synchronisers, so the data level seen at
  // a filtered clock edge is the bit that stood before the pin edge
  // rising link clock edge, found on the filtered level
  assign link_rise = link_clk_lvl & ~link_clk_prev;

  // shift bits msb first; a deselect throws away any partial byte
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      link_clk_prev <= 1'b0;
      shift <= 7'h00;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      byte_is_param <= 1'b0;
      byte_val <= 8'h00;
    end else begin
      link_clk_prev <= link_clk_lvl;
      byte_done <= 1'b0;
      if (link_sel_n_lvl) begin
        bit_cnt <= 3'h0;
      end else if (link_rise) begin
        shift <= {shift[5:0], link_data_lvl};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == `LAST_BIT) begin
          byte_done <= 1'b1;
          byte_val <= {shift, link_data_lvl};
          byte_is_param <= link_dc_lvl;
        end
      end
    end
  end

  // opcode and parameter handling; a command byte always starts afresh,
  // so a parameter that never came simply leaves the old value in force
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      param_pending <= 1'b0;
      pending_op <= 8'h00;
      invert_on <= 1'b0;
      force_black <= 1'b0;
      force_white <= 1'b0;
      // the panel starts blanked so nothing shows before the host is ready
      blank_on <= `RST_BLANK;
      sync_on <= 1'b0;
      reduced_color <= 1'b0;
      gamma_curve_out <= `RST_CURVE;
      scan_order_control <= `RST_SCAN_ORDER;
      sync_output_mode <= `RST_SYNC_MODE;
    end else begin
      // normal and partial mode come from elsewhere in the chip
      if (normal_mode_cmd_in || partial_mode_cmd_in) begin
        force_black <= 1'b0;
        force_white <= 1'b0;
      end
      // a command byte wins over a normal or partial pulse in the same cycle
      if (byte_done && !byte_is_param) begin
        param_pending <= 1'b0;
        pending_op <= byte_val;
        case (byte_val)
          `OP_INV_OFF: invert_on <= 1'b0;
          // setting an already set flag is naturally a no-op
          `OP_INV_ON: invert_on <= 1'b1;
          `OP_ALL_BLACK: begin
            force_black <= 1'b1;
            force_white <= 1'b0;
          end
          `OP_ALL_WHITE: begin
            force_white <= 1'b1;
            force_black <= 1'b0;
          end
          `OP_BLANK: blank_on <= 1'b1;
          `OP_SHOW: blank_on <= 1'b0;
          `OP_SYNC_OFF: sync_on <= 1'b0;
          `OP_RC_EXIT: reduced_color <= 1'b0;
          `OP_RC_ENTER: reduced_color <= 1'b1;
          `OP_CURVE_SEL: param_pending <= 1'b1;
          `OP_SYNC_ON: param_pending <= 1'b1;
          `OP_SCAN_ORDER: param_pending <= 1'b1;
          default: param_pending <= 1'b0;
        endcase
      end else if (byte_done && param_pending) begin
        // one parameter byte completes the command; a stray one with
        // nothing pending never gets here and is dropped
        param_pending <= 1'b0;
        case (pending_op)
          `OP_CURVE_SEL: begin
            case (byte_val)
              `CURVE_CODE_1: gamma_curve_out <= `CURVE_IDX_1;
              `CURVE_CODE_2: gamma_curve_out <= `CURVE_IDX_2;
              `CURVE_CODE_3: gamma_curve_out <= `CURVE_IDX_3;
              `CURVE_CODE_4: gamma_curve_out <= `CURVE_IDX_4;
              default: gamma_curve_out <= gamma_curve_out;
            endcase
          end
          `OP_SYNC_ON: begin
            // already on: the whole command is dropped, mode bit included
            if (!sync_on) begin
              sync_on <= 1'b1;
              sync_output_mode <= byte_val;
            end
          end
          `OP_SCAN_ORDER: scan_order_control <= byte_val;
          default: param_pending <= 1'b0;
        endcase
      end
    end
  end

  // scan order fields go straight out of the register
  // of the memory direction bits only the swap bit also steers the address stepper below
  assign row_order_out = scan_order_control[`SCAN_ROW_BIT];
  assign col_order_out = scan_order_control[`SCAN_COL_BIT];
  assign row_col_swap_out = scan_order_control[`SCAN_SWAP_BIT];
  assign vert_refresh_out = scan_order_control[`SCAN_VREF_BIT];
  assign filter_order_out = scan_order_control[`SCAN_FILTER_BIT];
  assign horiz_refresh_out = scan_order_control[`SCAN_HREF_BIT];
  assign source_scan_flip_out = scan_order_control[`SCAN_SRC_BIT];
  assign gate_scan_flip_out = scan_order_control[`SCAN_GATE_BIT];

  // dot rate enable for the scan counters; one clock domain only, so the
  // slower rate is a one-cycle pulse rather than a derived clock
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      dot_div <= 2'h0;
      dot_en <= 1'b0;
    end else begin
      dot_en <= (dot_div == `DOT_DIV);
      dot_div <= (dot_div == `DOT_DIV) ? 2'h0 : dot_div + 2'h1;
    end
  end

  scan_timing timing (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .dot_en_in(dot_en),
    .hblank_out(hblank),
    .vblank_out(vblank)
  );

  // sync output: off, sleeping, vertical only or vertical plus horizontal
  // registered so a mode change never glitches the pin
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      frame_sync_out <= 1'b0;
    end else if (!sync_on || sleep_in) begin
      frame_sync_out <= 1'b0;
    end else if (sync_output_mode[`LINE_KIND_BIT]) begin
      frame_sync_out <= vblank | hblank;
    end else begin
      frame_sync_out <= vblank;
    end
  end

  // pixel path: colour depth, inversion, component order, then overrides
  // flags are read live, so a command applies from the next valid pixel
  always @* begin
    next_pixel = pixel_in;
    if (reduced_color) begin
      next_pixel = {{8{pixel_in[23]}}, {8{pixel_in[15]}},
                    {8{pixel_in[7]}}};
    end
    if (invert_on)
      next_pixel = ~next_pixel;
    if (scan_order_control[`SCAN_FILTER_BIT])
      next_pixel = {next_pixel[7:0], next_pixel[15:8],
                    next_pixel[23:16]};
    // forced colours apply only while awake and ignore blanking
    if (!sleep_in && force_white)
      next_pixel = 24'hFFFFFF;
    else if (!sleep_in && force_black)
      next_pixel = 24'h000000;
    else if (blank_on || sleep_in)
      next_pixel = 24'h000000;
  end

  // output stage registers the pixel so the panel sees clean edges
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      pixel_out <= 24'h000000;
      pixel_valid_out <= 1'b0;
    end else begin
      pixel_valid_out <= pixel_valid_in;
      if (pixel_valid_in)
        pixel_out <= next_pixel;
    end
  end

  // host memory address stepper; order set by the swap bit
  // start wins over step, so a new burst never inherits a half row
  always @(posedge sys_clk_in) begin
    if (srst_in || mem_start_in) begin
      mem_col_out <= 11'h000;
      mem_page_out <= 12'h000;
    end else if (mem_step_in) begin
      if (!scan_order_control[`SCAN_SWAP_BIT]) begin
        if (mem_col_out == `COL_END) begin
          mem_col_out <= 11'h000;
          mem_page_out <= (mem_page_out == `PAGE_END) ? 12'h000 :
                          mem_page_out + 12'h001;
        end else begin
          mem_col_out <= mem_col_out + 11'h001;
        end
      end else begin
        if (mem_page_out == `PAGE_END) begin
          mem_page_out <= 12'h000;
          mem_col_out <= (mem_col_out == `COL_END) ? 11'h000 :
                         mem_col_out + 11'h001;
        end else begin
          mem_page_out <= mem_page_out + 12'h001;
        end
      end
    end
  end

  // mode flags mirrored out for status reads elsewhere
  // one cycle behind the flags, like pixel_out and frame_sync_out
  always @(posedge sys_clk_in) begin
    if (srst_in)
      mode_status_out <= 7'h00;
    else
      mode_status_out <= {sync_output_mode[`LINE_KIND_BIT], reduced_color,
                          sync_on, blank_on, force_white, force_black,
                          invert_on};
  end
endmodule // display_mode_command_decoder
`default_nettype wire

// ### rtl/display_cmd_map.vh
// constants for the display mode command decoder
`ifndef DISPLAY_CMD_MAP_VH
`define DISPLAY_CMD_MAP_VH
// command opcodes
`define OP_INV_OFF 8'h20
`define OP_INV_ON 8'h21
`define OP_ALL_BLACK 8'h22
`define OP_ALL_WHITE 8'h23
`define OP_CURVE_SEL 8'h26
`define OP_BLANK 8'h28
`define OP_SHOW 8'h29
`define OP_SYNC_OFF 8'h34
`define OP_SYNC_ON 8'h35
`define OP_SCAN_ORDER 8'h36
`define OP_RC_EXIT 8'h38
`define OP_RC_ENTER 8'h39
// curve_code one-hot values and the stored curve index
`define CURVE_CODE_1 8'h01
`define CURVE_CODE_2 8'h02
`define CURVE_CODE_3 8'h04
`define CURVE_CODE_4 8'h08
`define CURVE_IDX_1 2'h0
`define CURVE_IDX_2 2'h1
`define CURVE_IDX_3 2'h2
`define CURVE_IDX_4 2'h3
// scan_order_control field positions
`define SCAN_ROW_BIT 7
`define SCAN_COL_BIT 6
`define SCAN_SWAP_BIT 5
`define SCAN_VREF_BIT 4
`define SCAN_FILTER_BIT 3
`define SCAN_HREF_BIT 2
`define SCAN_SRC_BIT 1
`define SCAN_GATE_BIT 0
// sync_output_mode field position
`define LINE_KIND_BIT 0
// reset values
`define RST_SCAN_ORDER 8'h00
`define RST_SYNC_MODE 8'h00
`define RST_CURVE 2'h0
`define RST_BLANK 1'b1
// serial link: last bit index of a byte
`define LAST_BIT 3'h7
// dot rate divider: one enable every DOT_DIV+1 clocks
`define DOT_DIV 2'h3
// panel scan timing in dots and lines
`define H_ACTIVE 11'h320
`define H_LAST 11'h35F
`define V_ACTIVE 12'h500
`define V_LAST 12'h50F
// frame memory extents for the address stepper
`define COL_END 11'h31F
`define PAGE_END 12'h4FF
`endif

// ### rtl/pin_sync.v
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter RESET_LEVEL = 1'b0
) (
  input wire sys_clk_in,
  input wire srst_in,
  input wire pin_in,
  output reg level_out
);
  reg stage1;
  reg stage2;
  reg stage3;

  // stage1 feeds stage2 only; the level moves once stages 2 and 3 agree
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
      level_out <= RESET_LEVEL;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level_out <= stage3;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ### rtl/scan_timing.v
// dot and line counters giving horizontal and vertical blanking
`timescale 1ns/100ps
`default_nettype none
`include "display_cmd_map.vh"
module scan_timing (
  input wire sys_clk_in,
  input wire srst_in,
  input wire dot_en_in,
  output reg hblank_out,
  output reg vblank_out
);
  reg [10:0] dot;
  reg [11:0] line;

  // counters advance on the dot enable only; the refresh order bits do
  // not reach this module, so blanking timing never depends on them
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      dot <= 11'h000;
      line <= 12'h000;
      hblank_out <= 1'b0;
      vblank_out <= 1'b0;
    end else if (dot_en_in) begin
      if (dot == `H_LAST) begin
        dot <= 11'h000;
        line <= (line == `V_LAST) ? 12'h000 : line + 12'h001;
      end else begin
        dot <= dot + 11'h001;
      end
      hblank_out <= (dot >= `H_ACTIVE);
      vblank_out <= (line >= `V_ACTIVE);
    end
  end
endmodule // scan_timing
`default_nettype wire

// ### sim/host_link_model.sv
// host side of the serial display link: sends one byte per select frame
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
  output var logic clk_out,
  output var logic sel_n_out,
  output var logic dc_out,
  output var logic data_out
);
  // idle: deselected, link clock parked low between frames
  initial begin
    clk_out = 1'b0;
    sel_n_out = 1'b1;
    dc_out = 1'b0;
    data_out = 1'b0;
  end

  // msb first, 160 ns bit period; a parameter byte follows its command
  task automatic send(input logic dc, input logic [7:0] b);
    int k;
    sel_n_out = 1'b0;
    dc_out = dc;
    for (k = 7; k >= 0; k--) begin
      data_out = b[k];
      #80 clk_out = 1'b1;
      #80 clk_out = 1'b0;
    end
    #80 sel_n_out = 1'b1;
    // released lines have no keeper, so show the inverse of the last bit
    data_out = ~data_out;
    dc_out = ~dc_out;
    #80;
  endtask
endmodule // host_link_model
`default_nettype wire

// ### sim/display_mode_command_decoder_assertions.sv
// port-level checks for the display mode command decoder
`timescale 1ns/100ps
`default_nettype none
module display_mode_command_decoder_assertions (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic sleep_in,
  input wire logic [23:0] pixel_in,
  input wire logic pixel_valid_in,
  input wire logic mem_start_in,
  input wire logic mem_step_in,
  input wire logic [23:0] pixel_out,
  input wire logic frame_sync_out,
  input wire logic filter_order_out,
  input wire logic row_col_swap_out,
  input wire logic [10:0] mem_col_out,
  input wire logic [11:0] mem_page_out,
  input wire logic [6:0] mode_status_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  property p_sleep_sync;
    sleep_in |=> !frame_sync_out;
  endproperty
  a_sleep_sync: assert property (p_sleep_sync)
    else $error("sync output high while sleeping");
  property p_sync_off;
    !mode_status_out[4] |-> !frame_sync_out;
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sync output high while disabled");
  // pixel checks pair the flags seen one cycle later with the input pixel
  property p_white;
    (pixel_valid_in && !sleep_in) ##1 mode_status_out[2]
      |-> pixel_out == 24'hFFFFFF;
  endproperty
  a_white: assert property (p_white)
    else $error("forced white not shown");
  property p_black;
    (pixel_valid_in && !sleep_in) ##1 (mode_status_out[2:1] == 2'h1)
      |-> pixel_out == 24'h000000;
  endproperty
  a_black: assert property (p_black)
    else $error("forced black not shown");
  property p_blank;
    pixel_valid_in ##1 (mode_status_out[3:1] == 3'h4)
      |-> pixel_out == 24'h000000;
  endproperty
  a_blank: assert property (p_blank)
    else $error("blanked output not black");
  property p_invert;
    (pixel_valid_in && !sleep_in && !filter_order_out)
      ##1 ((mode_status_out[5:0] & 6'h2F) == 6'h01)
      |-> pixel_out == ~$past(pixel_in);
  endproperty
  a_invert: assert property (p_invert)
    else $error("inverted pixel wrong");
  property p_plain;
    (pixel_valid_in && !sleep_in && !filter_order_out)
      ##1 ((mode_status_out[5:0] & 6'h2F) == 6'h00)
      |-> pixel_out == $past(pixel_in);
  endproperty
  a_plain: assert property (p_plain)
    else $error("memory pixel not passed through");
  property p_start;
    mem_start_in |=> mem_col_out == 11'h000 && mem_page_out == 12'h000;
  endproperty
  a_start: assert property (p_start)
    else $error("stepper start address wrong");
  property p_step;
    mem_step_in && !mem_start_in && !row_col_swap_out
      && mem_col_out != 11'h31F
      |=> mem_col_out == $past(mem_col_out) + 11'h001
      && $stable(mem_page_out);
  endproperty
  a_step: assert property (p_step)
    else $error("column step wrong");
  property p_wrap;
    mem_step_in && !mem_start_in && !row_col_swap_out
      && mem_col_out == 11'h31F && mem_page_out != 12'h4FF
      |=> mem_col_out == 11'h000
      && mem_page_out == $past(mem_page_out) + 12'h001;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("column wrap wrong");
endmodule // display_mode_command_decoder_assertions

bind display_mode_command_decoder display_mode_command_decoder_assertions
  u_display_mode_command_decoder_assertions (.sys_clk_in, .srst_in,
  .sleep_in, .pixel_in, .pixel_valid_in, .mem_start_in, .mem_step_in,
  .pixel_out, .frame_sync_out, .filter_order_out, .row_col_swap_out,
  .mem_col_out, .mem_page_out, .mode_status_out);
`default_nettype wire

// ### sim/display_mode_command_decoder_tb.sv
// self-checking bench for the display mode command decoder
`timescale 1ns/100ps
`default_nettype none
module display_mode_command_decoder_tb;
  logic clk, rst, sleep, nrm, prt, pv, st, stp;
  wire lclk, lsel, ldc, ldat, pvo, fs;
  logic [23:0] pin;
  wire [23:0] pout;
  wire [1:0] gam;
  wire [7:0] scan;
  wire [10:0] col;
  wire [11:0] page;
  wire [6:0] ms;
  int num_errors = 0;
  int n_compared = 0;
  int i;
  int nhi;

  display_mode_command_decoder u_display_mode_command_decoder (
    .sys_clk_in(clk), .srst_in(rst), .link_clk_in(lclk),
    .link_sel_n_in(lsel), .link_dc_in(ldc), .link_data_in(ldat),
    .sleep_in(sleep), .normal_mode_cmd_in(nrm), .partial_mode_cmd_in(prt),
    .pixel_in(pin), .pixel_valid_in(pv), .mem_start_in(st),
    .mem_step_in(stp), .pixel_out(pout), .pixel_valid_out(pvo),
    .frame_sync_out(fs), .gamma_curve_out(gam), .row_order_out(scan[7]),
    .col_order_out(scan[6]), .row_col_swap_out(scan[5]),
    .vert_refresh_out(scan[4]), .filter_order_out(scan[3]),
    .horiz_refresh_out(scan[2]), .source_scan_flip_out(scan[1]),
    .gate_scan_flip_out(scan[0]), .mem_col_out(col), .mem_page_out(page),
    .mode_status_out(ms));
  host_link_model u_host_link_model (.clk_out(lclk), .sel_n_out(lsel),
    .dc_out(ldc), .data_out(ldat));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one link byte, then time for the flags to settle
  task automatic op(input logic dc, input logic [7:0] b);
    u_host_link_model.send(dc, b);
    repeat (20) @(negedge clk);
  endtask

  task automatic px(input logic [23:0] v);
    pin = v;
    pv = 1'b1;
    @(negedge clk);
    pv = 1'b0;
    chk(pvo, 1'b1);
  endtask

  task automatic pls(input logic p);
    prt = p;
    nrm = ~p;
    @(negedge clk);
    prt = 1'b0;
    nrm = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // one whole line period of 864 dots at 4 clocks; a frame is far longer,
  // so only line blanking shows: 64 dots, 256 clocks, at any phase
  task automatic watch;
    nhi = 0;
    repeat (3456) begin
      @(negedge clk);
      if (fs === 1'b1)
        nhi++;
    end
  endtask

  task automatic t_show_invert;
    chk(ms, 7'h08);
    chk(gam, 2'h0);
    op(1'b0, 8'h29);
    op(1'b0, 8'h29);
    chk(ms, 7'h00);
    op(1'b0, 8'h21);
    op(1'b0, 8'h21);
    chk(ms, 7'h01);
    px(24'h12A5F0);
    chk(pout, 24'hED5A0F);
    op(1'b0, 8'h20);
    op(1'b0, 8'h28);
    op(1'b0, 8'h28);
    chk(ms, 7'h08);
    px(24'h12A5F0);
    chk(pout, 24'h000000);
    op(1'b0, 8'h29);
  endtask

  task automatic t_forced;
    op(1'b0, 8'h22);
    px(24'h5A5A5A);
    chk(pout, 24'h000000);
    op(1'b0, 8'h28);
    op(1'b0, 8'h23);
    chk(ms, 7'h0C);
    px(24'h5A5A5A);
    chk(pout, 24'hFFFFFF);
    op(1'b0, 8'h29);
    op(1'b0, 8'h22);
    chk(ms, 7'h02);
    pls(1'b1);
    chk(ms, 7'h00);
    op(1'b0, 8'h23);
    pls(1'b0);
    chk(ms, 7'h00);
    px(24'h5A5A5A);
    chk(pout, 24'h5A5A5A);
  endtask

  task automatic t_gamma;
    for (i = 0; i < 4; i++) begin
      op(1'b0, 8'h26);
      op(1'b1, 8'h01 << i);
      chk(gam, i[1:0]);
    end
    op(1'b0, 8'h26);
    op(1'b1, 8'h03);
    chk(gam, 2'h3);
    op(1'b0, 8'h26);
    op(1'b1, 8'h00);
    op(1'b1, 8'h01);
    chk(gam, 2'h3);
  endtask

  task automatic t_scan_colour;
    op(1'b0, 8'h36);
    op(1'b1, 8'hA5);
    chk(scan, 8'hA5);
    op(1'b0, 8'h36);
    op(1'b1, 8'h5A);
    chk(scan, 8'h5A);
    chk(ms, 7'h00);
    op(1'b0, 8'h36);
    op(1'b1, 8'h08);
    px(24'h112233);
    chk(pout, 24'h332211);
    op(1'b0, 8'h36);
    op(1'b1, 8'h00);
    op(1'b0, 8'h39);
    px(24'h807FFF);
    chk(pout, 24'hFF00FF);
    op(1'b0, 8'h38);
    op(1'b0, 8'h38);
    chk(ms, 7'h00);
    px(24'h807FFF);
    chk(pout, 24'h807FFF);
  endtask

  task automatic t_sync;
    op(1'b0, 8'h35);
    op(1'b1, 8'hFE);
    chk(ms, 7'h10);
    watch();
    chk(nhi, 32'h0);
    // enabling again while on must leave the line kind alone
    op(1'b0, 8'h35);
    op(1'b1, 8'h01);
    chk(ms, 7'h10);
    op(1'b0, 8'h34);
    op(1'b0, 8'h35);
    op(1'b1, 8'h01);
    chk(ms, 7'h50);
    watch();
    chk(nhi, 32'h100);
    op(1'b0, 8'h36);
    op(1'b1, 8'h10);
    watch();
    chk(nhi, 32'h100);
    sleep = 1'b1;
    watch();
    chk(nhi, 32'h0);
    sleep = 1'b0;
    op(1'b0, 8'h34);
    op(1'b0, 8'h34);
    chk(ms[4], 1'b0);
    watch();
    chk(nhi, 32'h0);
  endtask

  task automatic t_step;
    op(1'b0, 8'h36);
    op(1'b1, 8'h00);
    st = 1'b1;
    @(negedge clk);
    st = 1'b0;
    stp = 1'b1;
    repeat (800) @(negedge clk);
    stp = 1'b0;
    chk({col, page}, {11'h000, 12'h001});
    op(1'b0, 8'h36);
    op(1'b1, 8'h20);
    st = 1'b1;
    @(negedge clk);
    st = 1'b0;
    stp = 1'b1;
    repeat (3) @(negedge clk);
    stp = 1'b0;
    chk({col, page}, {11'h000, 12'h003});
  endtask

  initial begin
    rst = 1'b1;
    sleep = 1'b0;
    nrm = 1'b0;
    prt = 1'b0;
    pv = 1'b0;
    st = 1'b0;
    stp = 1'b0;
    pin = 24'h000000;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_show_invert();
    t_forced();
    t_gamma();
    t_scan_colour();
    t_sync();
    t_step();
    complete_run();
  end

  // cut a hang well past the expected run of some 23000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule // display_mode_command_decoder_tb
`default_nettype wire
